// ---- rtl/cpu8_decode_regs.svh ----
// constants of the compare/logic opcode decoder: opcodes, nibbles, cycles
// assumes inclusion by the mode mapper and decoder modules only
// How it works
// - opcodes x1 in rows A-F, prefixed D1/E1, decode as accumulator compare
// - every compare changes only condition_flags, never A, X, H or memory
// - 3E, 65, 75, prefixed F3 compare H:X with word; 6, 3, 5, 6 cycles
// - opcodes x3 in rows A-F, prefixed D3/E3, decode as low index compare
// - opcode 72 decodes as one-cycle BCD adjust of the accumulator
// - 3B-7B, prefixed 6B: decrement M, A or X, branch when result nonzero
// - the X form 5B writes only the low index byte, never H
// - opcode 52 divides H:A by X, quotient to A, remainder to H, 6 cycles
// - opcodes x8 in rows A-F, prefixed D8/E8: A gets A xor memory
`ifndef CPU8_DECODE_REGS_SVH
`define CPU8_DECODE_REGS_SVH

`define OPC_PREFIX 8'h9E
`define OPC_BCD_ADJUST 8'h72
`define OPC_DIVIDE 8'h52
`define OPC_PAIR_EXT 8'h3E
`define OPC_PAIR_IMM 8'h65
`define OPC_PAIR_DIR 8'h75
`define OPC_PAIR_SP1 8'hF3
`define OPC_DEC_BRANCH_NONZERO_OP_DIR 8'h3B
`define OPC_DEC_BRANCH_NONZERO_OP_ACC 8'h4B
`define OPC_DEC_BRANCH_NONZERO_OP_XLOW 8'h5B
`define OPC_DEC_BRANCH_NONZERO_OP_IX1 8'h6B
`define OPC_DEC_BRANCH_NONZERO_OP_IX 8'h7B

`define LN_ACC_COMPARE 4'h1
`define LN_XLOW_COMPARE 4'h3
`define LN_ACC_XOR 4'h8
`define HN_IMM 4'hA
`define HN_DIR 4'hB
`define HN_EXT 4'hC
`define HN_IX2 4'hD
`define HN_IX1 4'hE
`define HN_IX 4'hF

`define CYC_IMM 4'h2
`define CYC_DIR 4'h3
`define CYC_EXT 4'h4
`define CYC_IX2 4'h4
`define CYC_IX1 4'h3
`define CYC_IX 4'h3
`define CYC_SP2 4'h5
`define CYC_SP1 4'h4
`define CYC_PAIR_EXT 4'h6
`define CYC_PAIR_IMM 4'h3
`define CYC_PAIR_DIR 4'h5
`define CYC_PAIR_SP1 4'h6
`define CYC_BCD_ADJUST 4'h1
`define CYC_DIVIDE 4'h6
`define CYC_DEC_BRANCH_NONZERO_OP_DIR 4'h7
`define CYC_DEC_BRANCH_NONZERO_OP_INH 4'h4
`define CYC_DEC_BRANCH_NONZERO_OP_IX1 4'h7
`define CYC_DEC_BRANCH_NONZERO_OP_IX 4'h6
`define CYC_DEC_BRANCH_NONZERO_OP_SP1 4'h8

`endif

// ---- rtl/cpu8_decode_pkg.sv ----
// types shared by the opcode decoder and its addressing-mode mapper
// assumes nothing beyond a SystemVerilog compiler
package cpu8_decode_pkg;

  typedef enum logic [3:0] {
    op_none = 4'b0000,
    acc_compare_op = 4'b0001,
    index_pair_compare_op = 4'b0010,
    index_low_compare_op = 4'b0011,
    bcd_adjust_op = 4'b0100,
    dec_branch_nonzero_op = 4'b0101,
    dec_branch_nonzero_xlow_op = 4'b0110,
    unsigned_divide_op = 4'b0111,
    acc_xor_op = 4'b1000
  } op_e;

  typedef enum logic [3:0] {
    mode_inh = 4'b0000,
    mode_imm = 4'b0001,
    mode_dir = 4'b0010,
    mode_ext = 4'b0011,
    mode_ix2 = 4'b0100,
    mode_ix1 = 4'b0101,
    mode_ix = 4'b0110,
    mode_sp2 = 4'b0111,
    mode_sp1 = 4'b1000,
    mode_imm16 = 4'b1001
  } mode_e;

  typedef enum logic [2:0] {
    alu_pass = 3'b000,
    alu_sub8 = 3'b001,
    alu_sub16 = 3'b010,
    alu_xor = 3'b011,
    alu_dec = 3'b100,
    alu_bcd = 3'b101,
    alu_div = 3'b110
  } alu_e;

endpackage : cpu8_decode_pkg

// ---- rtl/cpu8_mode_map.sv ----
// maps the high opcode nibble of the eight-mode families to a mode and
// cycle count; purely combinational, fed from the decoder
`include "cpu8_decode_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module cpu8_mode_map
  import cpu8_decode_pkg::*;
(
  input wire logic [3:0] high_nibble,
  input wire logic sp_form,
  output mode_e mode,
  output logic [3:0] cycles
);

  always_comb begin
    unique case (high_nibble)
      `HN_IMM: begin
        mode = mode_imm;
        cycles = `CYC_IMM;
      end
      `HN_DIR: begin
        mode = mode_dir;
        cycles = `CYC_DIR;
      end
      `HN_EXT: begin
        mode = mode_ext;
        cycles = `CYC_EXT;
      end
      `HN_IX2: begin
        mode = sp_form ? mode_sp2 : mode_ix2;
        cycles = sp_form ? `CYC_SP2 : `CYC_IX2;
      end
      `HN_IX1: begin
        mode = sp_form ? mode_sp1 : mode_ix1;
        cycles = sp_form ? `CYC_SP1 : `CYC_IX1;
      end
      `HN_IX: begin
        mode = mode_ix;
        cycles = `CYC_IX;
      end
      default: begin
        mode = mode_inh;
        cycles = 4'h0;
      end
    endcase
  end

endmodule : cpu8_mode_map
`default_nettype wire

// ---- rtl/cpu8_compare_logic_decode.sv ----
// opcode decoder for compare, bcd adjust, decrement-branch, divide, xor
// assumes opcode bytes arrive from fetch on clk, one per in_valid pulse
`include "cpu8_decode_regs.svh"
`timescale 1ns/100ps
`default_nettype none
module cpu8_compare_logic_decode
  import cpu8_decode_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [7:0] in_byte,
  output logic prefix_active,
  output logic dec_valid,
  output logic not_mine,
  output op_e op_class,
  output mode_e addr_mode,
  output alu_e alu_sel,
  output logic [3:0] cycles,
  output logic sp_based,
  output logic wide16,
  output logic flags_only,
  output logic writes_acc,
  output logic writes_xlow,
  output logic writes_h,
  output logic writes_mem,
  output logic branch_nonzero,
  output logic keep_h
);

  logic take;
  logic is_prefix;
  logic fam_row;
  mode_e fam_mode;
  logic [3:0] fam_cycles;
  logic next_hit;
  op_e next_op;
  mode_e next_mode;
  alu_e next_alu;
  logic [3:0] next_cycles;
  logic next_wide;
  logic next_flags_only;
  logic next_wacc;
  logic next_wxlow;
  logic next_wh;
  logic next_wmem;
  logic next_branch;
  logic next_keep_h;

  assign take = ce && in_valid;
  assign is_prefix = !prefix_active && (in_byte == `OPC_PREFIX);
  // prefixed family bytes only exist in rows D and E
  assign fam_row = (in_byte[7:4] >= `HN_IMM) &&
    (!prefix_active || in_byte[7:4] == `HN_IX2 ||
     in_byte[7:4] == `HN_IX1);

  cpu8_mode_map u_mode_map (
    .high_nibble(in_byte[7:4]),
    .sp_form(prefix_active),
    .mode(fam_mode),
    .cycles(fam_cycles)
  );

  always_comb begin
    next_hit = 1'b1;
    next_op = op_none;
    next_mode = mode_inh;
    next_alu = alu_pass;
    next_cycles = 4'h0;
    next_wide = 1'b0;
    next_flags_only = 1'b0;
    next_wacc = 1'b0;
    next_wxlow = 1'b0;
    next_wh = 1'b0;
    next_wmem = 1'b0;
    next_branch = 1'b0;
    next_keep_h = 1'b0;
    if (prefix_active && in_byte == `OPC_PAIR_SP1) begin
      next_op = index_pair_compare_op;
      next_mode = mode_sp1;
      next_alu = alu_sub16;
      next_cycles = `CYC_PAIR_SP1;
      next_wide = 1'b1;
      next_flags_only = 1'b1;
    end else if (prefix_active && in_byte == `OPC_DEC_BRANCH_NONZERO_OP_IX1) begin
      next_op = dec_branch_nonzero_op;
      next_mode = mode_sp1;
      next_alu = alu_dec;
      next_cycles = `CYC_DEC_BRANCH_NONZERO_OP_SP1;
      next_wmem = 1'b1;
      next_branch = 1'b1;
    end else if (fam_row && in_byte[3:0] == `LN_ACC_COMPARE) begin
      next_op = acc_compare_op;
      next_mode = fam_mode;
      next_alu = alu_sub8;
      next_cycles = fam_cycles;
      next_flags_only = 1'b1;
    end else if (fam_row && in_byte[3:0] == `LN_XLOW_COMPARE) begin
      next_op = index_low_compare_op;
      next_mode = fam_mode;
      next_alu = alu_sub8;
      next_cycles = fam_cycles;
      next_flags_only = 1'b1;
    end else if (fam_row && in_byte[3:0] == `LN_ACC_XOR) begin
      next_op = acc_xor_op;
      next_mode = fam_mode;
      next_alu = alu_xor;
      next_cycles = fam_cycles;
      next_wacc = 1'b1;
    end else if (prefix_active) begin
      next_hit = 1'b0;
    end else begin
      unique case (in_byte)
        `OPC_PAIR_EXT, `OPC_PAIR_IMM, `OPC_PAIR_DIR: begin
          next_op = index_pair_compare_op;
          next_alu = alu_sub16;
          next_wide = 1'b1;
          next_flags_only = 1'b1;
          if (in_byte == `OPC_PAIR_EXT) begin
            next_mode = mode_ext;
            next_cycles = `CYC_PAIR_EXT;
          end else if (in_byte == `OPC_PAIR_IMM) begin
            next_mode = mode_imm16;
            next_cycles = `CYC_PAIR_IMM;
          end else begin
            next_mode = mode_dir;
            next_cycles = `CYC_PAIR_DIR;
          end
        end
        `OPC_BCD_ADJUST: begin
          next_op = bcd_adjust_op;
          next_alu = alu_bcd;
          next_cycles = `CYC_BCD_ADJUST;
          next_wacc = 1'b1;
        end
        `OPC_DIVIDE: begin
          next_op = unsigned_divide_op;
          next_alu = alu_div;
          next_cycles = `CYC_DIVIDE;
          next_wacc = 1'b1;
          next_wh = 1'b1;
        end
        `OPC_DEC_BRANCH_NONZERO_OP_DIR, `OPC_DEC_BRANCH_NONZERO_OP_IX1, `OPC_DEC_BRANCH_NONZERO_OP_IX: begin
          next_op = dec_branch_nonzero_op;
          next_alu = alu_dec;
          next_wmem = 1'b1;
          next_branch = 1'b1;
          if (in_byte == `OPC_DEC_BRANCH_NONZERO_OP_DIR) begin
            next_mode = mode_dir;
            next_cycles = `CYC_DEC_BRANCH_NONZERO_OP_DIR;
          end else if (in_byte == `OPC_DEC_BRANCH_NONZERO_OP_IX1) begin
            next_mode = mode_ix1;
            next_cycles = `CYC_DEC_BRANCH_NONZERO_OP_IX1;
          end else begin
            next_mode = mode_ix;
            next_cycles = `CYC_DEC_BRANCH_NONZERO_OP_IX;
          end
        end
        `OPC_DEC_BRANCH_NONZERO_OP_ACC: begin
          next_op = dec_branch_nonzero_op;
          next_alu = alu_dec;
          next_cycles = `CYC_DEC_BRANCH_NONZERO_OP_INH;
          next_wacc = 1'b1;
          next_branch = 1'b1;
        end
        `OPC_DEC_BRANCH_NONZERO_OP_XLOW: begin
          next_op = dec_branch_nonzero_xlow_op;
          next_alu = alu_dec;
          next_cycles = `CYC_DEC_BRANCH_NONZERO_OP_INH;
          next_wxlow = 1'b1;
          next_keep_h = 1'b1;
          next_branch = 1'b1;
        end
        default: next_hit = 1'b0;
      endcase
    end
  end

  // prefix holds for exactly the next opcode byte
  always_ff @(posedge clk) begin
    if (!nrst) begin
      prefix_active <= 1'b0;
    end else if (take) begin
      prefix_active <= is_prefix;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      dec_valid <= 1'b0;
      not_mine <= 1'b0;
      sp_based <= 1'b0;
    end else if (ce) begin
      dec_valid <= in_valid && !is_prefix && next_hit;
      not_mine <= in_valid && !is_prefix && !next_hit;
      if (in_valid) begin
        sp_based <= prefix_active && next_hit;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      op_class <= op_none;
      addr_mode <= mode_inh;
      alu_sel <= alu_pass;
      cycles <= 4'h0;
      wide16 <= 1'b0;
      flags_only <= 1'b0;
      writes_acc <= 1'b0;
      writes_xlow <= 1'b0;
      writes_h <= 1'b0;
      writes_mem <= 1'b0;
      branch_nonzero <= 1'b0;
      keep_h <= 1'b0;
    end else if (take && !is_prefix) begin
      op_class <= next_op;
      addr_mode <= next_mode;
      alu_sel <= next_alu;
      cycles <= next_cycles;
      wide16 <= next_wide;
      flags_only <= next_flags_only;
      writes_acc <= next_wacc;
      writes_xlow <= next_wxlow;
      writes_h <= next_wh;
      writes_mem <= next_wmem;
      branch_nonzero <= next_branch;
      keep_h <= next_keep_h;
    end
  end

  default clocking dc @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_acc_cmp_imm: assert property (
    take && !prefix_active && in_byte == 8'hA1 |=>
    dec_valid && op_class == acc_compare_op && addr_mode == mode_imm)
    else $error("A1 not decoded as immediate accumulator compare");
  chk_compare_flags_only: assert property (
    dec_valid && (op_class == acc_compare_op ||
    op_class == index_low_compare_op ||
    op_class == index_pair_compare_op) |->
    flags_only && !writes_acc && !writes_xlow && !writes_h && !writes_mem)
    else $error("compare writes a register or memory");
  chk_pair_imm_cycles: assert property (
    take && !prefix_active && in_byte == 8'h65 |=>
    op_class == index_pair_compare_op && cycles == 4'h3 && wide16)
    else $error("16-bit immediate pair compare wrong");
  chk_pair_sp_cycles: assert property (
    take && prefix_active && in_byte == 8'hF3 |=>
    op_class == index_pair_compare_op && cycles == 4'h6 && sp_based)
    else $error("prefixed F3 not a stack pair compare of 6 cycles");
  chk_xlow_cmp_sp: assert property (
    take && prefix_active && in_byte == 8'hE3 |=>
    op_class == index_low_compare_op && addr_mode == mode_sp1)
    else $error("prefixed E3 not a stack low index compare");
  chk_bcd_one_cycle: assert property (
    take && !prefix_active && in_byte == 8'h72 |=>
    op_class == bcd_adjust_op && cycles == 4'h1 && writes_acc)
    else $error("bcd adjust decode wrong");
  chk_dec_branch_nonzero_op_branches: assert property (
    dec_valid && $rose(dec_valid) && alu_sel == alu_dec |->
    branch_nonzero && (writes_acc || writes_xlow || writes_mem))
    else $error("decrement form without nonzero branch");
  chk_xlow_keeps_h: assert property (
    dec_valid && op_class == dec_branch_nonzero_xlow_op |->
    keep_h && writes_xlow && !writes_h)
    else $error("X decrement touches H");
  chk_div_result: assert property (
    take && !prefix_active && in_byte == 8'h52 |=>
    op_class == unsigned_divide_op && cycles == 4'h6 &&
    writes_acc && writes_h)
    else $error("divide decode wrong");
  chk_xor_to_acc: assert property (
    dec_valid && op_class == acc_xor_op |->
    writes_acc && alu_sel == alu_xor && !flags_only)
    else $error("xor result not routed to accumulator");
  chk_prefix_held: assert property (
    take && !prefix_active && in_byte == 8'h9E |=>
    prefix_active && !dec_valid && !not_mine)
    else $error("prefix byte not held");
  chk_row_ext_map: assert property (
    take && !prefix_active && in_byte == 8'hC8 |=>
    addr_mode == mode_ext && cycles == 4'h4)
    else $error("row C not mapped to extended");

  cov_sp_compare: cover property (
    take && is_prefix ##1 take && in_byte == 8'hD1);
  cov_dec_branch_nonzero_op_xlow: cover property (
    dec_valid && op_class == dec_branch_nonzero_xlow_op);
  cov_divide: cover property (dec_valid && op_class == unsigned_divide_op);
  cov_foreign: cover property (not_mine);

endmodule : cpu8_compare_logic_decode
`default_nettype wire

// ---- dv/cpu8_fetch_model.sv ----
// fetch-side model: hands queued opcode bytes to the decoder in order
// assumes the decoder takes a byte on a rising edge with nrst, ce, in_valid
`timescale 1ns/100ps
`default_nettype none
module cpu8_fetch_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  output logic in_valid,
  output logic [7:0] in_byte
);
  logic [7:0] q[$];
  logic taken;

  // opcode bytes only, never operand bytes
  task automatic send(input logic [7:0] b);
    q.push_back(b);
  endtask : send

  initial begin
    in_valid = 1'b0;
    in_byte = 8'h00;
  end

  // a byte stands until taken; idle lines toggle so stale data cannot match
  always @(posedge clk) begin
    taken = in_valid && ce && nrst;
    #1;
    if (taken) void'(q.pop_front());
    in_valid = (q.size() != 0);
    in_byte = in_valid ? q[0] : ~in_byte;
  end
endmodule : cpu8_fetch_model
`default_nettype wire

// ---- dv/tb.sv ----
// self-checking bench for the compare/logic opcode decoder
// assumes cpu8_fetch_model and the decoder package are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb
  import cpu8_decode_pkg::*;
();
  logic clk, nrst, ce, in_valid, prefix_active, dec_valid, not_mine;
  logic sp_based, wide16, flags_only, writes_acc, writes_xlow, writes_h;
  logic writes_mem, branch_nonzero, keep_h, pend, stall_en, ce_edge;
  logic [7:0] in_byte;
  logic [3:0] cycles;
  op_e op_class;
  mode_e addr_mode;
  alu_e alu_sel;
  logic [24:0] outs;
  logic [25:0] e;
  logic [25:0] exp_q[$];
  integer seed, bad_count, total_checks;

  assign outs = {prefix_active, op_class, addr_mode, alu_sel, cycles,
    sp_based, wide16, flags_only, writes_acc, writes_xlow, writes_h,
    writes_mem, branch_nonzero, keep_h};

  cpu8_compare_logic_decode DUT (.clk(clk), .nrst(nrst), .ce(ce),
    .in_valid(in_valid), .in_byte(in_byte),
    .prefix_active(prefix_active), .dec_valid(dec_valid),
    .not_mine(not_mine), .op_class(op_class), .addr_mode(addr_mode),
    .alu_sel(alu_sel), .cycles(cycles), .sp_based(sp_based),
    .wide16(wide16), .flags_only(flags_only), .writes_acc(writes_acc),
    .writes_xlow(writes_xlow), .writes_h(writes_h),
    .writes_mem(writes_mem), .branch_nonzero(branch_nonzero),
    .keep_h(keep_h));

  cpu8_fetch_model fetch (.clk(clk), .nrst(nrst), .ce(ce),
    .in_valid(in_valid), .in_byte(in_byte));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // random clock-enable stalls
  always @(posedge clk) begin
    #1;
    ce = stall_en ? (($random(seed) & 3) != 0) : 1'b1;
  end

  // expected record: not_mine, then the outs layout
  function automatic logic [25:0] expect_of(input logic pf,
                                            input logic [7:0] b);
    logic [3:0] hi, lo, cy;
    op_e op;
    mode_e md;
    alu_e al;
    logic fam, w16, fo, wa, wx, wh, wm, br, kh;
    hi = b[7:4];
    lo = b[3:0];
    op = op_none;
    md = mode_inh;
    al = alu_pass;
    cy = 4'h0;
    {w16, fo, wa, wx, wh, wm, br, kh} = 8'h00;
    fam = (lo == 4'h1 || lo == 4'h3 || lo == 4'h8);
    fam = fam && (pf ? (hi == 4'hD || hi == 4'hE) : hi >= 4'hA);
    if (fam) begin
      op = (lo == 4'h1) ? acc_compare_op : index_low_compare_op;
      op = (lo == 4'h8) ? acc_xor_op : op;
      al = (lo == 4'h8) ? alu_xor : alu_sub8;
      fo = (lo != 4'h8);
      wa = (lo == 4'h8);
      md = pf ? ((hi == 4'hD) ? mode_sp2 : mode_sp1) : mode_e'(hi - 4'h9);
      cy = (hi == 4'hA) ? 4'h2 : (hi == 4'hC || hi == 4'hD) ? 4'h4 : 4'h3;
      cy = pf ? ((hi == 4'hD) ? 4'h5 : 4'h4) : cy;
    end
    case ({pf, b})
      9'h03E: begin md = mode_ext; cy = 4'h6; end
      9'h065: begin md = mode_imm16; cy = 4'h3; end
      9'h075: begin md = mode_dir; cy = 4'h5; end
      9'h1F3: begin md = mode_sp1; cy = 4'h6; end
      9'h072: begin op = bcd_adjust_op; al = alu_bcd; cy = 4'h1; wa = 1'b1; end
      9'h052: begin op = unsigned_divide_op; al = alu_div; cy = 4'h6; wa = 1'b1; wh = 1'b1; end
      9'h03B: begin md = mode_dir; cy = 4'h7; wm = 1'b1; end
      9'h04B: begin cy = 4'h4; wa = 1'b1; end
      9'h05B: begin cy = 4'h4; wx = 1'b1; kh = 1'b1; end
      9'h06B: begin md = mode_ix1; cy = 4'h7; wm = 1'b1; end
      9'h07B: begin md = mode_ix; cy = 4'h6; wm = 1'b1; end
      9'h16B: begin md = mode_sp1; cy = 4'h8; wm = 1'b1; end
      default: ;
    endcase
    if ({pf, b} inside {9'h03E, 9'h065, 9'h075, 9'h1F3}) begin
      op = index_pair_compare_op;
      al = alu_sub16;
      w16 = 1'b1;
      fo = 1'b1;
    end
    if (cy != 4'h0 && lo == 4'hB) begin
      op = (b == 8'h5B) ? dec_branch_nonzero_xlow_op : dec_branch_nonzero_op;
      al = alu_dec;
      br = 1'b1;
    end
    return {cy == 4'h0, 1'b0, op, md, al, cy, pf, w16, fo, wa, wx, wh, wm,
            br, kh};
  endfunction : expect_of

  task automatic check(input logic [24:0] got, input logic [24:0] want);
    total_checks++;
    if (got !== want) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, want);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic put(input logic [7:0] b);
    fetch.send(b);
    if (pend) exp_q.push_back(expect_of(1'b1, b));
    else if (b != 8'h9E) exp_q.push_back(expect_of(1'b0, b));
    pend = !pend && (b == 8'h9E);
  endtask : put

  task automatic drain();
    int n;
    n = 0;
    while ((fetch.q.size() != 0 || exp_q.size() != 0) && n < 3000) begin
      @(posedge clk);
      #3;
      n++;
    end
    if (n == 3000) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, exp_q.size(), 0);
      final_report();
    end
  endtask : drain

  // a new pulse only follows an edge with ce high
  always @(posedge clk) begin
    ce_edge = ce && nrst;
    #2;
    if (ce_edge && (dec_valid === 1'b1 || not_mine === 1'b1)) begin
      e = 26'h000_0000;
      if (exp_q.size() != 0) e = exp_q.pop_front();
      check({23'h0, dec_valid, not_mine}, {23'h0, !e[25], e[25]});
      if (!e[25]) check(outs, e[24:0]);
    end
  end

  initial begin
    seed = 34;
    bad_count = 0;
    total_checks = 0;
    pend = 1'b0;
    stall_en = 1'b0;
    nrst = 1'b0;
    ce = 1'b1;
    repeat (3) @(posedge clk);
    #1 nrst = 1'b1;
    #1;
    check(outs, 25'h000_0000);
    check({23'h0, dec_valid, not_mine}, 25'h000_0000);
    // every byte but 9E plain, then every byte behind a prefix, back to back
    for (int i = 0; i < 256; i++) if (i != 'h9E) put(i[7:0]);
    for (int i = 0; i < 256; i++) begin
      put(8'h9E);
      put(i[7:0]);
    end
    drain();
    stall_en = 1'b1;
    for (int i = 0; i < 400; i++)
      put((($random(seed) & 7) == 0) ? 8'h9E : 8'($random(seed)));
    if (pend) put(8'hE8);
    drain();
    // prefix holds while idle, reset clears it
    stall_en = 1'b0;
    put(8'h9E);
    drain();
    repeat (2) @(posedge clk);
    #3;
    check({24'h0, prefix_active}, 25'h000_0001);
    @(posedge clk);
    #1 nrst = 1'b0;
    @(posedge clk);
    #1 nrst = 1'b1;
    pend = 1'b0;
    #1;
    check({24'h0, prefix_active}, 25'h000_0000);
    put(8'hA1);
    drain();
    final_report();
  end
endmodule : tb
`default_nettype wire
